// ---- src/hdop_pkg.sv ----
// constants, register map and state type of the handler digital output port
package hdop_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ          = 40;       // system clock rate
  localparam int unsigned SKEW_US          = 10;       // category setup and hold around the strobe
  localparam int unsigned SKEW_CYC         = SKEW_US * CLK_MHZ;
  localparam int unsigned DELAY_DEF_US     = 100;      // auto-clear delay after reset
  localparam int unsigned DELAY_DEF_CYC    = DELAY_DEF_US * CLK_MHZ;
  localparam int unsigned DELAY_MAX_S      = 60;       // longest auto-clear delay
  localparam longint unsigned DELAY_MAX_CYC = longint'(DELAY_MAX_S) * 1000000 * CLK_MHZ;

  // register byte addresses
  localparam logic [7:0] ADDR_IDLE_PATTERN = 8'h00;    // programmed idle pattern, rw
  localparam logic [7:0] ADDR_CONTROL      = 8'h04;    // port configuration, rw
  localparam logic [7:0] ADDR_CLEAR_DELAY  = 8'h08;    // auto-clear delay in clock cycles, rw
  localparam logic [7:0] ADDR_COMMAND      = 8'h0C;    // action bits, write only
  localparam logic [7:0] ADDR_ACTUAL       = 8'h10;    // pattern on the lines, ro
  localparam logic [7:0] ADDR_STATUS       = 8'h14;    // sequencer state, ro

  // control field positions
  localparam int unsigned CTL_WIDTH_BIT    = 0;        // port_width_select: 0 three, 1 four lines
  localparam int unsigned CTL_FUNC_BIT     = 1;        // line_four_function: 0 strobe, 1 busy
  localparam int unsigned CTL_POL_BIT      = 2;        // line_four_polarity: 1 active high
  localparam int unsigned CTL_AUTO_BIT     = 3;        // auto-clear enable
  localparam logic [3:0]  CTL_RESET        = 4'h8;     // three-bit, strobe, active low, auto-clear on

  // command field positions
  localparam int unsigned CMD_CLEAR_BIT    = 0;        // immediate clear

  localparam logic [3:0]  IDLE_RESET       = 4'h0;     // idle pattern after reset
  localparam logic [3:0]  LINES_RESET      = 4'h8;     // idle zero, line four inactive high (active low)

  // output sequencer
  typedef enum logic [2:0] {
    ST_IDLE,     // idle pattern on the lines
    ST_SETUP,    // category lines set, strobe not yet active
    ST_STROBE,   // strobe active for the auto-clear delay
    ST_HOLD,     // strobe gone, categories still held
    ST_HELD      // categories held until a clear command or a new result
  } hdop_state_t;

endpackage : hdop_pkg

// ---- src/hdop_timer.sv ----
// down counter that times one interval of the output sequencer
`timescale 1ns/1ps
module hdop_timer #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  input  wire logic             load_in,   // start a new interval
  input  wire logic [WIDTH-1:0] value_in,  // interval length in cycles, at least one
  output logic                  done_out   // last cycle of the interval
);

  logic [WIDTH-1:0] count_r;               // cycles left

  // load wins over counting so back-to-back intervals join seamlessly
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_r <= '0;
    end else if (load_in) begin
      count_r <= value_in;
    end else if (count_r != '0) begin
      count_r <= count_r - WIDTH'(1);
    end
  end

  // a value of n gives n cycles from the load edge to the edge after done
  assign done_out = (count_r == WIDTH'(1));

endmodule : hdop_timer

// ---- src/hdop_port.sv ----
// handler digital output port: register file, output sequencer and line drivers
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module hdop_port
  import hdop_pkg::*;
#(
  parameter longint unsigned MAX_DELAY_CYC = DELAY_MAX_CYC,  // cap on the auto-clear delay
  parameter int unsigned     SKEW_CYCLES   = SKEW_CYC        // setup and hold of category lines
) (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // limit-test result and instrument busy
  input  wire logic [3:0]  result_pattern_in,   // pass or fail category pattern
  input  wire logic        result_valid_in,     // one-cycle pulse: present the pattern
  input  wire logic        busy_in,             // instrument busy level
  // handler lines, bit 0 is line one
  output logic      [3:0]  lines_out
);

  localparam logic [31:0] SKEW_LOAD = 32'(SKEW_CYCLES);
  localparam logic [31:0] DELAY_CAP = 32'(MAX_DELAY_CYC);

  logic [3:0]  idle_r;          // programmed idle pattern
  logic [3:0]  ctl_r;           // port configuration
  logic [31:0] delay_r;         // auto-clear delay in cycles
  logic [3:0]  result_r;        // category pattern of the present result
  logic [3:0]  lines_r;         // registered line drive
  logic [3:0]  lines_nxt;
  logic [31:0] rdata_r;
  hdop_state_t state_r;
  hdop_state_t state_nxt;
  logic        clear_cmd;       // immediate clear written this cycle
  logic        load;            // start a timed interval
  logic [31:0] load_val;
  logic        tmr_done;
  logic [3:0]  cat;             // category pattern in force
  logic        four_bit;
  logic        busy_mode;
  logic        pol_high;
  logic        auto_en;
  logic        strobe_act;

  assign four_bit  = ctl_r[CTL_WIDTH_BIT];
  assign busy_mode = ctl_r[CTL_FUNC_BIT];
  assign pol_high  = ctl_r[CTL_POL_BIT];
  assign auto_en   = ctl_r[CTL_AUTO_BIT];
  assign clear_cmd = wr_in && (addr_in == ADDR_COMMAND) && wdata_in[CMD_CLEAR_BIT];

  // idle pattern register; all four bits are kept, three-bit mode just leaves bit 3 unused
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      idle_r <= IDLE_RESET;
    end else if (wr_in && addr_in == ADDR_IDLE_PATTERN) begin
      idle_r <= wdata_in[3:0];
    end
  end

  // configuration register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl_r <= CTL_RESET;
    end else if (wr_in && addr_in == ADDR_CONTROL) begin
      ctl_r <= wdata_in[3:0];
    end
  end

  // delay register; values past the longest delay saturate rather than wrap
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      delay_r <= 32'(DELAY_DEF_CYC);
    end else if (wr_in && addr_in == ADDR_CLEAR_DELAY) begin
      delay_r <= (wdata_in > DELAY_CAP) ? DELAY_CAP : wdata_in;
    end
  end

  // result latch: taken only when a new result may start
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_r <= IDLE_RESET;
    end else if (result_valid_in && !clear_cmd && (state_r == ST_IDLE || state_r == ST_HELD)) begin
      result_r <= result_pattern_in;
    end
  end

  // sequencer next state and interval loads; clear takes priority over everything
  always_comb begin
    state_nxt = state_r;
    load      = 1'b0;
    load_val  = SKEW_LOAD;
    if (clear_cmd) begin
      state_nxt = ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_HELD: begin
          if (result_valid_in) begin          // results arriving mid-sequence are dropped
            state_nxt = ST_SETUP;
            load      = 1'b1;
          end
        end
        ST_SETUP: begin
          if (tmr_done) begin
            load = 1'b1;
            if (delay_r == '0) begin          // zero delay: no strobe at all
              state_nxt = ST_HOLD;
            end else begin
              state_nxt = ST_STROBE;
              load_val  = delay_r;
            end
          end
        end
        ST_STROBE: begin
          if (tmr_done) begin
            state_nxt = ST_HOLD;
            load      = 1'b1;
          end
        end
        ST_HOLD: begin
          if (tmr_done) begin
            state_nxt = auto_en ? ST_IDLE : ST_HELD;
          end
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  hdop_timer #(
    .WIDTH    (32)
  ) u_timer (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .load_in  (load),
    .value_in (load_val),
    .done_out (tmr_done)
  );

  // line drive: categories span setup, strobe and hold, so they bracket line four
  always_comb begin
    cat        = (state_r == ST_IDLE) ? idle_r : result_r;
    strobe_act = (state_r == ST_STROBE);
    lines_nxt  = cat;
    if (busy_mode) begin
      lines_nxt[3] = pol_high ? busy_in : !busy_in;
    end else if (!four_bit) begin
      lines_nxt[3] = pol_high ? strobe_act : !strobe_act;
    end else begin
      lines_nxt[3] = cat[3];
    end
  end

  // output flops keep the lines glitch free toward the handler
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lines_r <= LINES_RESET;   // three-bit strobe mode, active low: line four inactive high
    end else begin
      lines_r <= lines_nxt;
    end
  end

  assign lines_out = lines_r;

  // read data stands the cycle after the strobe only
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        ADDR_IDLE_PATTERN: rdata_r <= {28'h000_0000, idle_r};
        ADDR_CONTROL:      rdata_r <= {28'h000_0000, ctl_r};
        ADDR_CLEAR_DELAY:  rdata_r <= delay_r;
        ADDR_ACTUAL:       rdata_r <= {28'h000_0000, lines_r};
        ADDR_STATUS:       rdata_r <= {29'h0000_0000, state_r};
        default:           rdata_r <= '0;                         // command and unmapped
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_out = rdata_r;

  // checking helpers: cycles spent in the present state, and whether control was written
  logic [31:0] dwell_r;
  logic        ctl_written_r;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dwell_r       <= '0;
      ctl_written_r <= 1'b0;
    end else begin
      dwell_r       <= (state_nxt != state_r) ? 32'h0000_0000 : dwell_r + 32'h0000_0001;
      ctl_written_r <= ctl_written_r || (wr_in && addr_in == ADDR_CONTROL);
    end
  end

  // checks: one clock domain, all of them quiet while reset is low
  // they watch what this block drives and also the stimulus, such as result_valid_in, busy_in and rd_in
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  // a result accepted from idle opens the setup interval
  sequence seq_start;
    (state_r == ST_IDLE) && result_valid_in && !clear_cmd ##1 (state_r == ST_SETUP);
  endsequence

  // last hold cycle, not cut short by a clear
  sequence seq_leave_hold;
    (state_r == ST_HOLD) && tmr_done && !clear_cmd;
  endsequence

  // last setup cycle, not cut short by a clear
  sequence seq_leave_setup;
    (state_r == ST_SETUP) && tmr_done && !clear_cmd;
  endsequence

  AST_IDLE_MAP: assert property (
    (state_r == ST_IDLE) && $past(state_r == ST_IDLE) && $stable(idle_r) && $past(rstn_in)
    |-> lines_out[2:0] == idle_r[2:0])
    else $error("idle pattern not on lines one to three");

  AST_STROBE_POL: assert property (
    !four_bit && !busy_mode && $stable(ctl_r) ##1 (state_r == ST_STROBE) && $stable(ctl_r)
    |=> lines_out[3] == $past(pol_high))
    else $error("line four strobe level wrong for polarity");

  AST_BUSY_LINE: assert property (
    busy_mode ##1 busy_mode && $stable(ctl_r) |-> lines_out[3] == ($past(busy_in) ~^ pol_high))
    else $error("busy level not on line four");

  AST_FOUR_BIT_EOT: assert property (
    four_bit && !busy_mode && (state_r == ST_STROBE) && $stable(ctl_r) |=> lines_out[3] == result_r[3])
    else $error("four-bit line four not taken from pattern");

  AST_CLEAR_NOW: assert property (
    clear_cmd ##1 !result_valid_in |-> (state_r == ST_IDLE) ##1 (lines_out[2:0] == $past(idle_r[2:0]))[*2])
    else $error("clear did not restore idle pattern");

  AST_AUTO_CLEAR: assert property (
    seq_leave_hold ##0 auto_en |=> (state_r == ST_IDLE))
    else $error("auto-clear did not return to idle");

  AST_HOLD_PATTERN: assert property (
    seq_leave_hold ##0 !auto_en |=> (state_r == ST_HELD))
    else $error("pattern not held without auto-clear");

  AST_HELD_STAYS: assert property (
    (state_r == ST_HELD) && !clear_cmd && !result_valid_in |=> (state_r == ST_HELD))
    else $error("held pattern left without a clear");

  AST_RESET_AUTO: assert property (
    !ctl_written_r |-> auto_en)
    else $error("auto-clear not enabled after reset");

  AST_STROBE_WIDTH: assert property (
    (state_r == ST_STROBE) && tmr_done && !clear_cmd |-> dwell_r == delay_r - 32'h0000_0001)
    else $error("strobe width differs from delay");

  AST_SKEW_SETUP: assert property (
    seq_leave_setup |-> dwell_r == SKEW_LOAD - 32'h0000_0001)
    else $error("category setup before strobe is not the skew time");

  AST_SKEW_HOLD: assert property (
    seq_leave_hold |-> dwell_r == SKEW_LOAD - 32'h0000_0001)
    else $error("category hold after strobe is not the skew time");

  AST_TIMER_LOAD: assert property (
    $rose(state_r == ST_SETUP) |-> $past(load) && $past(load_val) == SKEW_LOAD)
    else $error("timer not loaded when a result is presented");

  // categories must reach the lines before line four can move
  AST_SETUP_LINES: assert property (
    seq_start |=> lines_out[2:0] == result_r[2:0])
    else $error("categories not on the lines at setup");

  AST_LINE4_IDLE: assert property (
    !four_bit && !busy_mode && (state_r != ST_STROBE) |=> lines_out[3] == !$past(pol_high))
    else $error("line four strobe active outside the strobe interval");

  AST_FOUR_BIT_IDLE: assert property (
    four_bit && !busy_mode && (state_r == ST_IDLE) |=> lines_out[3] == $past(idle_r[3]))
    else $error("four-bit idle pattern bit 3 not on line four");

  // both patterns stay readable on their own addresses
  AST_IDLE_READ: assert property (
    rd_in && (addr_in == ADDR_IDLE_PATTERN) |=> rdata_out == {28'h000_0000, $past(idle_r)})
    else $error("idle pattern read back wrong");

  AST_ACTUAL_READ: assert property (
    rd_in && (addr_in == ADDR_ACTUAL) |=> rdata_out == {28'h000_0000, $past(lines_out)})
    else $error("actual line pattern read back wrong");

endmodule : hdop_port

// ---- tb/hdop_handler_model.sv ----
// handler model: takes the categories on the leading edge of the line-four strobe
`timescale 1ns/1ps
module hdop_handler_model (
  input  wire logic       clock_in,
  input  wire logic [3:0] lines_in,   // handler lines, bit 0 is line one
  input  wire logic       active_in,  // level at which line four strobes
  output logic      [2:0] cat_out,    // categories taken at the strobe
  output int              width_out   // length of the last strobe in cycles
);
  logic act_q = 1'b0;  // strobe seen on the previous edge
  int   cnt   = 0;     // cycles of the strobe so far
  initial cat_out = 3'h0;
  initial width_out = 0;
  // a real handler only looks at the lines on its strobe, so glitches elsewhere pass unseen
  always @(posedge clock_in) begin
    act_q <= (lines_in[3] === active_in);
    if (lines_in[3] === active_in) begin
      cnt <= cnt + 1;
      if (!act_q) cat_out <= lines_in[2:0];
    end else if (act_q) begin
      width_out <= cnt;
      cnt <= 0;
    end
  end
endmodule : hdop_handler_model

// ---- tb/handler_digital_output_port_tb.sv ----
// self-checking bench of the handler digital output port
`timescale 1ns/1ps
module handler_digital_output_port_tb;
  import hdop_pkg::*;
  localparam int S = 4;  // shortened skew keeps the run brief
  localparam int D = 6;  // short auto-clear delay in cycles
  logic        clock_in, rstn_in, wr_in, rd_in, result_valid_in, busy_in, pol;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, rdata_out;
  logic [3:0]  result_pattern_in, lines_out;
  logic [2:0]  cat;
  int          width;
  int          fails = 0;
  int          checks_done = 0;

  hdop_port #(.MAX_DELAY_CYC(1000), .SKEW_CYCLES(S)) DUT (
    .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .result_pattern_in(result_pattern_in),
    .result_valid_in(result_valid_in), .busy_in(busy_in), .lines_out(lines_out));
  hdop_handler_model handler (.clock_in(clock_in), .lines_in(lines_out), .active_in(pol),
    .cat_out(cat), .width_out(width));

  // free-running system clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  // one write cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr

  // one read cycle; data stand only in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 cmp(rdata_out, exp, "read data");
  endtask : rd

  // look at the lines n edges on, once they settled
  task automatic ln(input int n, input logic [3:0] exp);
    repeat (n) @(posedge clock_in);
    #1 cmp({28'h0, lines_out}, {28'h0, exp}, "lines");
  endtask : ln

  // one-cycle result pulse; returns at the accept edge
  task automatic fire(input logic [3:0] p);
    @(posedge clock_in);
    result_pattern_in <= p;
    result_valid_in   <= 1'b1;
    @(posedge clock_in);
    result_valid_in <= 1'b0;
  endtask : fire

  task automatic t_reset;
    cmp({28'h0, lines_out}, 32'h8, "reset lines");
    rd(ADDR_CONTROL, 32'h8);
    rd(ADDR_IDLE_PATTERN, 32'h0);
    rd(8'h20, 32'h0);
    rd(ADDR_COMMAND, 32'h0);
  endtask : t_reset

  task automatic t_idle;
    wr(ADDR_IDLE_PATTERN, 32'hD);
    ln(1, 4'hD);
    rd(ADDR_ACTUAL, 32'hD);
    rd(ADDR_IDLE_PATTERN, 32'hD);
    wr(ADDR_CONTROL, 32'h9);
    wr(ADDR_IDLE_PATTERN, 32'hA);
    ln(1, 4'hA);
    rd(ADDR_ACTUAL, 32'hA);
  endtask : t_idle

  // three-bit, strobe active high, auto-clear; result bit 3 must not reach line four
  task automatic t_strobe;
    pol = 1'b1;
    wr(ADDR_CONTROL, 32'hC);
    wr(ADDR_IDLE_PATTERN, 32'h2);
    wr(ADDR_CLEAR_DELAY, D);
    ln(1, 4'h2);
    fire(4'hD);
    ln(1, 4'h5);
    ln(S - 1, 4'h5);
    ln(1, 4'hD);
    ln(D - 1, 4'hD);
    ln(1, 4'h5);
    ln(S - 1, 4'h5);
    ln(1, 4'h2);
    cmp(width, D, "strobe width");
    cmp({29'h0, cat}, 32'h5, "categories");
  endtask : t_strobe

  // auto-clear off, active low: pattern held until the clear command
  task automatic t_hold;
    pol = 1'b0;
    wr(ADDR_CONTROL, 32'h0);
    ln(1, 4'hA);
    fire(4'h3);
    ln(2, 4'hB);
    ln(S, 4'h3);
    ln(D, 4'hB);
    ln(S + 20, 4'hB);
    rd(ADDR_STATUS, 32'h4);
    cmp(width, D, "low strobe width");
    wr(ADDR_COMMAND, 32'h1);
    ln(1, 4'hA);
  endtask : t_hold

  // delay saturates at the cap; zero delay gives no strobe at all
  task automatic t_zero;
    pol = 1'b1;
    wr(ADDR_CLEAR_DELAY, 32'd5000);
    rd(ADDR_CLEAR_DELAY, 32'd1000);
    wr(ADDR_CONTROL, 32'hC);
    wr(ADDR_CLEAR_DELAY, 32'h0);
    fire(4'h5);
    ln(1, 4'h5);
    ln(S, 4'h5);
    ln(S - 1, 4'h5);
    ln(1, 4'h2);
  endtask : t_zero

  // four-bit strobe mode: line four follows the pattern only
  task automatic t_four;
    wr(ADDR_CONTROL, 32'hD);
    wr(ADDR_CLEAR_DELAY, D);
    fire(4'h1);
    ln(2, 4'h1);
    ln(S, 4'h1);
    ln(D, 4'h1);
    ln(S, 4'h2);
  endtask : t_four

  // busy mode: line four tracks busy through the polarity, pattern bit 3 ignored
  task automatic t_busy;
    wr(ADDR_IDLE_PATTERN, 32'hA);
    wr(ADDR_CONTROL, 32'hF);
    ln(4, 4'h2);
    @(posedge clock_in) busy_in <= 1'b1;
    ln(4, 4'hA);
    wr(ADDR_CONTROL, 32'hA);
    ln(4, 4'h2);
    @(posedge clock_in) busy_in <= 1'b0;
    ln(4, 4'hA);
  endtask : t_busy

  // main sequence
  initial begin
    rstn_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0000_0000;
    result_pattern_in = 4'h0;
    result_valid_in = 1'b0;
    busy_in = 1'b0;
    pol = 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    #1;
    t_reset();
    t_idle();
    t_strobe();
    t_hold();
    t_zero();
    t_four();
    t_busy();
    stop_test();
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #(25 * 20000);
    fails++;
    stop_test();
  end
endmodule : handler_digital_output_port_tb
